// *** lhrg_cfg.svh ***
// Constants for the linear home-return grid block
//
// Behaviour
// - Grid spacing follows stop-interval code 0..6; code 3 after reset.
// - Incremental encoder: grid anchored at first reference mark after home start.
// - Dog return: home is nearest grid point reached after dog turns off.
// - Encoder index pulse never anchors the grid.
// - Absolute encoder: grid anchored at absolute position zero.
// - Data-set return adopts current position as home at once.
// - Test switch blocks network traffic for self and all downstream drives.
// - All axes enter test together; only the selected axis may move.
// - Test mode accepts positioning, output forcing and program run from registers.
`ifndef LHRG_CFG_SVH
`define LHRG_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define LHRG_ADDR_CTRL 8'h00
`define LHRG_ADDR_STAT 8'h04
`define LHRG_ADDR_POS 8'h08
`define LHRG_ADDR_HOME 8'h0c
`define LHRG_ADDR_IRQS 8'h10
`define LHRG_ADDR_IRQM 8'h14
`define LHRG_ADDR_TEST 8'h18
`define LHRG_ADDR_DOF 8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LHRG_CTRL_START 0
`define LHRG_CTRL_ABS 1
`define LHRG_CTRL_DSET 2
`define LHRG_CTRL_NEG 3
`define LHRG_CTRL_CODE 6:4
`define LHRG_STAT_BUSY 0
`define LHRG_STAT_REF 1
`define LHRG_STAT_HOMED 2
`define LHRG_STAT_TEST 3
`define LHRG_STAT_ANCH 4
`define LHRG_IRQ_HOME 0
`define LHRG_IRQ_REF 1
`define LHRG_IRQ_REJ 2
`define LHRG_TEST_AXIS 2:0
`define LHRG_TEST_MOVP 4
`define LHRG_TEST_MOVN 5
`define LHRG_TEST_PROG 6
`define LHRG_DOF_VAL 7:0
`define LHRG_DOF_EN 8

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define LHRG_CODE_DEF 3'h3
`define LHRG_CODE_MAX 3'h6
`define LHRG_MAX_AXES 8

// ----------------------------------------------------------------
// Stop intervals in pulses
// ----------------------------------------------------------------
`define LHRG_STOP_0 32'h0000_2000
`define LHRG_STOP_1 32'h0002_0000
`define LHRG_STOP_2 32'h0004_0000
`define LHRG_STOP_3 32'h0010_0000
`define LHRG_STOP_4 32'h0040_0000
`define LHRG_STOP_5 32'h0100_0000
`define LHRG_STOP_6 32'h0400_0000

`endif

// *** lhrg_pkg.sv ***
// Types shared by the linear home-return grid block
package lhrg_pkg;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_DOG = 2'b01,
    H_SEEK = 2'b10
  } lhrg_home_t;

  // Pins from the machine side, all asynchronous
  typedef struct packed {
    logic step;
    logic dir;
    logic refMark;
    logic dog;
    logic testSw;
    logic netUp;
  } lhrg_pins_t;

  typedef struct packed {
    lhrg_home_t hst;
    logic [31:0] pos;
    logic [31:0] anchor;
    logic [31:0] homePos;
    logic anchorValid;
    logic refSeen;
    logic targetValid;
    logic homed;
    logic dogWasOn;
    logic stepPrev;
    logic refPrev;
    logic [2:0] code;
    logic absEnc;
    logic dataSet;
    logic dirNeg;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic testMode;
    logic strapDone;
    logic [2:0] axisSel;
    logic movePos;
    logic moveNeg;
    logic progRun;
    logic [7:0] axisEn;
    logic [7:0] doForce;
    logic doForceEn;
    logic netDown;
    logic ready;
    logic slvErr;
    logic [31:0] rdata;
  } lhrg_state_t;

endpackage

// *** lhrg_sync.sv ***
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module lhrg_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Pins
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lhrg_sync_t;

  lhrg_sync_t q, d;

  // No reset: the strap must be valid in the first cycle after reset release
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign dout = q.s2;
endmodule
`default_nettype wire

// *** lhrg_grid.sv ***
// Rounds an offset from the grid anchor onto the stop-interval grid
`timescale 1ns/1ps
`default_nettype none
`include "lhrg_cfg.svh"
module lhrg_grid import lhrg_pkg::*; (
  // Offset from anchor
  input wire logic [31:0] offset,
  input wire logic [2:0] code,
  input wire logic dirNeg,
  // Grid point ahead in travel direction
  output logic [31:0] gridOff
);
  function automatic logic [31:0] intervalOf(input logic [2:0] c);
    unique case (c)
      3'h0: intervalOf = `LHRG_STOP_0;
      3'h1: intervalOf = `LHRG_STOP_1;
      3'h2: intervalOf = `LHRG_STOP_2;
      3'h3: intervalOf = `LHRG_STOP_3;
      3'h4: intervalOf = `LHRG_STOP_4;
      3'h5: intervalOf = `LHRG_STOP_5;
      3'h6: intervalOf = `LHRG_STOP_6;
      default: intervalOf = `LHRG_STOP_3;
    endcase
  endfunction

  logic [31:0] mask;

  // Intervals are powers of two, so rounding is a mask
  always_comb begin
    mask = intervalOf(code) - 32'h1;
    if (dirNeg) begin
      gridOff = offset & ~mask;
    end else begin
      gridOff = (offset + mask) & ~mask;
    end
  end
endmodule
`default_nettype wire

// *** lhrg_top.sv ***
// Home-return grid, test mode and network gate with APB registers
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lhrg_cfg.svh"
module lhrg_top import lhrg_pkg::*; #(
  parameter int NAXES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder and machine pins
  input wire lhrg_pins_t pinsIn,
  input wire logic encoderIndexPulse,
  input wire logic [31:0] absPos,
  input wire logic absLoad,
  // Network gate
  output logic netSelfEn,
  output logic netDownOut,
  // Test operation
  output logic [NAXES-1:0] axisMoveEn,
  output logic testMovePos,
  output logic testMoveNeg,
  output logic testProgRun,
  output logic [7:0] doForceVal,
  output logic doForceEn,
  // Home status
  output logic homeBusy,
  output logic homeDone,
  output logic [31:0] homePos,
  output logic [31:0] posNow,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NAXES < 1 || NAXES > `LHRG_MAX_AXES) begin : gBadAxes
    $error("NAXES out of range");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lhrg_state_t s_q, s_d;
  lhrg_pins_t pinsSync;
  logic stepEdge, refEdge, reached;
  logic access, wrEn, rdEn;
  logic [31:0] offset, gridOff, target;
  logic [2:0] irqSet, irqClr;
  logic [2:0] newCode;
  // One bit wider than the axis field, so eight axes still compare correctly
  localparam logic [3:0] AXIS_LIMIT = 4'(NAXES);

  function automatic logic regMapped(input logic [7:0] a);
    unique case (a)
      `LHRG_ADDR_CTRL, `LHRG_ADDR_STAT, `LHRG_ADDR_POS, `LHRG_ADDR_HOME,
      `LHRG_ADDR_IRQS, `LHRG_ADDR_IRQM, `LHRG_ADDR_TEST, `LHRG_ADDR_DOF:
        regMapped = 1'b1;
      default: regMapped = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and grid arithmetic
  // ----------------------------------------------------------------
  lhrg_sync #(
    .W($bits(lhrg_pins_t))
  ) uSync (
    .clk(clk),
    .din(pinsIn),
    .dout(pinsSync)
  );

  // Index pulse is left unread on purpose: only the reference mark, or zero in absolute mode, anchors
  assign offset = s_q.pos - s_q.anchor;

  lhrg_grid uGrid (
    .offset(offset),
    .code(s_q.code),
    .dirNeg(s_q.dirNeg),
    .gridOff(gridOff)
  );

  assign target = gridOff + s_q.anchor;
  assign stepEdge = pinsSync.step & ~s_q.stepPrev;
  assign refEdge = pinsSync.refMark & ~s_q.refPrev;
  assign reached = s_q.dirNeg ? ($signed(s_q.pos) <= $signed(s_q.homePos))
                              : ($signed(s_q.pos) >= $signed(s_q.homePos));

  // One wait state: ready rises on the second access cycle
  assign access = psel & penable;
  assign wrEn = access & s_q.ready & pwrite & regMapped(paddr);
  assign rdEn = access & ~s_q.ready;
  assign newCode = pwdata[`LHRG_CTRL_CODE];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    irqSet = 3'h0;
    irqClr = 3'h0;

    // Strap caught once after reset; a later flip has no effect
    if (!s_q.strapDone) begin
      s_d.strapDone = 1'b1;
      s_d.testMode = pinsSync.testSw;
    end

    // Position counter
    s_d.stepPrev = pinsSync.step;
    s_d.refPrev = pinsSync.refMark;
    if (stepEdge) begin
      s_d.pos = pinsSync.dir ? s_q.pos - 32'h1 : s_q.pos + 32'h1;
    end
    if (absLoad && s_q.absEnc) begin
      s_d.pos = absPos;
    end

    // First reference mark after start anchors the grid
    if (refEdge && s_q.hst != H_IDLE && !s_q.refSeen && !s_q.absEnc) begin
      s_d.refSeen = 1'b1;
      s_d.anchor = s_q.pos;
      s_d.anchorValid = 1'b1;
      irqSet[`LHRG_IRQ_REF] = 1'b1;
    end

    // Home-return sequence
    unique case (s_q.hst)
      H_IDLE: begin
      end
      H_DOG: begin
        if (pinsSync.dog) begin
          s_d.dogWasOn = 1'b1;
        end else if (s_q.dogWasOn) begin
          s_d.hst = H_SEEK;
        end
      end
      H_SEEK: begin
        if (!s_q.targetValid) begin
          // Without an anchor the wait goes on; the controller flags it
          if (s_q.anchorValid) begin
            s_d.homePos = target;
            s_d.targetValid = 1'b1;
          end
        end else if (reached) begin
          s_d.homed = 1'b1;
          s_d.hst = H_IDLE;
          irqSet[`LHRG_IRQ_HOME] = 1'b1;
        end
      end
      default: begin
        s_d.hst = H_IDLE;
      end
    endcase

    // APB answer
    s_d.ready = rdEn;
    s_d.slvErr = rdEn & ~regMapped(paddr);
    if (rdEn) begin
      unique case (paddr)
        `LHRG_ADDR_CTRL: begin
          s_d.rdata = 32'h0;
          s_d.rdata[`LHRG_CTRL_ABS] = s_q.absEnc;
          s_d.rdata[`LHRG_CTRL_DSET] = s_q.dataSet;
          s_d.rdata[`LHRG_CTRL_NEG] = s_q.dirNeg;
          s_d.rdata[`LHRG_CTRL_CODE] = s_q.code;
        end
        `LHRG_ADDR_STAT: begin
          s_d.rdata = 32'h0;
          s_d.rdata[`LHRG_STAT_BUSY] = (s_q.hst != H_IDLE);
          s_d.rdata[`LHRG_STAT_REF] = s_q.refSeen;
          s_d.rdata[`LHRG_STAT_HOMED] = s_q.homed;
          s_d.rdata[`LHRG_STAT_TEST] = s_q.testMode;
          s_d.rdata[`LHRG_STAT_ANCH] = s_q.anchorValid;
        end
        `LHRG_ADDR_POS: s_d.rdata = s_q.pos;
        `LHRG_ADDR_HOME: s_d.rdata = s_q.homePos;
        `LHRG_ADDR_IRQS: s_d.rdata = {29'h0, s_q.irqStat};
        `LHRG_ADDR_IRQM: s_d.rdata = {29'h0, s_q.irqMask};
        `LHRG_ADDR_TEST: begin
          s_d.rdata = 32'h0;
          s_d.rdata[`LHRG_TEST_AXIS] = s_q.axisSel;
          s_d.rdata[`LHRG_TEST_MOVP] = s_q.movePos;
          s_d.rdata[`LHRG_TEST_MOVN] = s_q.moveNeg;
          s_d.rdata[`LHRG_TEST_PROG] = s_q.progRun;
        end
        `LHRG_ADDR_DOF: begin
          s_d.rdata = 32'h0;
          s_d.rdata[`LHRG_DOF_VAL] = s_q.doForce;
          s_d.rdata[`LHRG_DOF_EN] = s_q.doForceEn;
        end
        default: s_d.rdata = 32'h0;
      endcase
    end

    // APB writes
    if (wrEn) begin
      unique case (paddr)
        `LHRG_ADDR_CTRL: begin
          s_d.absEnc = pwdata[`LHRG_CTRL_ABS];
          s_d.dataSet = pwdata[`LHRG_CTRL_DSET];
          s_d.dirNeg = pwdata[`LHRG_CTRL_NEG];
          // Codes above six are ignored, keeping the last legal spacing
          if (newCode <= `LHRG_CODE_MAX) begin
            s_d.code = newCode;
          end
          if (pwdata[`LHRG_CTRL_START]) begin
            s_d.refSeen = 1'b0;
            s_d.dogWasOn = 1'b0;
            s_d.targetValid = 1'b0;
            s_d.homed = 1'b0;
            s_d.anchor = 32'h0;
            s_d.anchorValid = pwdata[`LHRG_CTRL_ABS];
            if (pwdata[`LHRG_CTRL_DSET]) begin
              s_d.homePos = s_q.pos;
              s_d.homed = 1'b1;
              s_d.hst = H_IDLE;
              irqSet[`LHRG_IRQ_HOME] = 1'b1;
            end else begin
              s_d.hst = H_DOG;
            end
          end
        end
        `LHRG_ADDR_IRQS: irqClr = pwdata[2:0];
        `LHRG_ADDR_IRQM: s_d.irqMask = pwdata[2:0];
        `LHRG_ADDR_TEST: begin
          // Commands only from the test port, one axis at a time
          if (s_q.testMode && {1'b0, pwdata[`LHRG_TEST_AXIS]} < AXIS_LIMIT) begin
            s_d.axisSel = pwdata[`LHRG_TEST_AXIS];
            s_d.movePos = pwdata[`LHRG_TEST_MOVP];
            s_d.moveNeg = pwdata[`LHRG_TEST_MOVN] & ~pwdata[`LHRG_TEST_MOVP];
            s_d.progRun = pwdata[`LHRG_TEST_PROG];
          end else begin
            irqSet[`LHRG_IRQ_REJ] = 1'b1;
          end
        end
        `LHRG_ADDR_DOF: begin
          if (s_q.testMode) begin
            s_d.doForce = pwdata[`LHRG_DOF_VAL];
            s_d.doForceEn = pwdata[`LHRG_DOF_EN];
          end else begin
            irqSet[`LHRG_IRQ_REJ] = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Set wins over a same-cycle clear
    s_d.irqStat = (s_q.irqStat & ~irqClr) | irqSet;

    // Every axis shares test mode; only the selected one gets motion
    for (int i = 0; i < `LHRG_MAX_AXES; i++) begin
      s_d.axisEn[i] = s_d.testMode && (i < NAXES) && (s_d.axisSel == i[2:0]) &&
                      (s_d.movePos || s_d.moveNeg || s_d.progRun);
    end

    // Test mode cuts the link here and for everything downstream
    s_d.netDown = s_d.testMode ? 1'b0 : pinsSync.netUp;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.hst <= H_IDLE;
      s_q.code <= `LHRG_CODE_DEF;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slvErr;
  assign netSelfEn = ~s_q.testMode;
  assign netDownOut = s_q.netDown;
  assign axisMoveEn = s_q.axisEn[NAXES-1:0];
  assign testMovePos = s_q.movePos;
  assign testMoveNeg = s_q.moveNeg;
  assign testProgRun = s_q.progRun;
  assign doForceVal = s_q.doForce;
  assign doForceEn = s_q.doForceEn;
  assign homeBusy = (s_q.hst != H_IDLE);
  assign homeDone = s_q.homed;
  assign homePos = s_q.homePos;
  assign posNow = s_q.pos;
  assign irq = |(s_q.irqStat & s_q.irqMask);

endmodule
`default_nettype wire

// *** lhrg_enc_model.sv ***
// Linear encoder and proximity dog model facing the home-return block
`timescale 1ns/1ps
`default_nettype none
module lhrg_enc_model (
  // Clock
  input wire logic clk,
  // Pins toward the drive
  output logic step,
  output logic dir,
  output logic refMark,
  output logic dog
);
  initial begin
    step = 1'b0;
    dir = 1'b0;
    refMark = 1'b0;
    dog = 1'b0;
  end

  // Marks and dog edges fall in the low half of a step, so counts are exact
  task automatic move(input int n, input int refIdx, input int dogOff, input logic down);
    dog <= 1'b1;
    dir <= down;
    repeat (4) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      step <= 1'b1;
      repeat (2) @(posedge clk);
      step <= 1'b0;
      @(posedge clk);
      refMark <= (i == refIdx);
      if (i == dogOff) begin
        dog <= 1'b0;
      end
      @(posedge clk);
      refMark <= 1'b0;
    end
    dog <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** lhrg_monitor.sv ***
// Port-level checker for the home-return block
`timescale 1ns/1ps
`default_nettype none
module lhrg_monitor import lhrg_pkg::*; #(
  parameter int NAXES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs watched
  input wire logic netSelfEn,
  input wire logic netDownOut,
  input wire logic [NAXES-1:0] axisMoveEn,
  input wire logic testMovePos,
  input wire logic testMoveNeg,
  input wire logic testProgRun,
  input wire logic homeBusy,
  input wire logic homeDone,
  input wire logic [31:0] homePos
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_ready_second: assert property (psel && penable && !pready |=> pready) else $error("ready late");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_net_block: assert property (!netSelfEn [*3] |-> !netDownOut)
    else $error("downstream link open in test");
  a_axis_onehot: assert property ($onehot0(axisMoveEn)) else $error("several axes");
  a_axis_cause: assert property (|axisMoveEn |-> !netSelfEn &&
    (testMovePos || testMoveNeg || testProgRun)) else $error("axis moves without command");
  a_dir_excl: assert property (!(testMovePos && testMoveNeg)) else $error("both dirs");
  a_done_idle: assert property (homeDone |-> !homeBusy) else $error("done while busy");
  a_home_hold: assert property (homeDone && !psel && !$past(psel) |=>
    homeDone && $stable(homePos)) else $error("home lost");
  a_dset_fast: assert property (psel && penable && pready && pwrite && paddr == 8'h00 &&
    pwdata[0] && pwdata[2] |-> ##[1:2] homeDone) else $error("data set slow");

  c_home: cover property (homeDone && !homeBusy);
  c_err: cover property (pslverr);
  c_axis: cover property (|axisMoveEn);
endmodule

bind lhrg_top lhrg_monitor #(.NAXES(NAXES)) u_mon (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .netSelfEn(netSelfEn), .netDownOut(netDownOut), .axisMoveEn(axisMoveEn),
  .testMovePos(testMovePos), .testMoveNeg(testMoveNeg), .testProgRun(testProgRun),
  .homeBusy(homeBusy), .homeDone(homeDone), .homePos(homePos));
`default_nettype wire

// *** lhrg_test.sv ***
// Self-checking bench for the home-return block
`timescale 1ns/1ps
`default_nettype none
module lhrg_test import lhrg_pkg::*;;
  localparam int NAX = 2;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, absLoad, idxPulse, testSw, netUp;
  logic step, dir, refMark, dog, netSelfEn, netDownOut, testMovePos, testMoveNeg, testProgRun;
  logic doForceEn, homeBusy, homeDone, irq, rerr;
  logic [7:0] paddr, doForceVal;
  logic [31:0] pwdata, prdata, absPos, homePos, posNow, rdat;
  logic [NAX-1:0] axisMoveEn;
  lhrg_pins_t pinsIn;
  int n_mismatch, cmp_count, cyc;
  logic [31:0] iv [7] = '{32'h2000, 32'h20000, 32'h40000, 32'h100000, 32'h400000,
    32'h1000000, 32'h4000000};

  assign pinsIn = '{step, dir, refMark, dog, testSw, netUp};
  lhrg_top #(.NAXES(NAX)) i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinsIn(pinsIn), .encoderIndexPulse(idxPulse), .absPos(absPos),
    .absLoad(absLoad), .netSelfEn(netSelfEn), .netDownOut(netDownOut),
    .axisMoveEn(axisMoveEn), .testMovePos(testMovePos), .testMoveNeg(testMoveNeg),
    .testProgRun(testProgRun), .doForceVal(doForceVal), .doForceEn(doForceEn),
    .homeBusy(homeBusy), .homeDone(homeDone), .homePos(homePos), .posNow(posNow), .irq(irq));
  lhrg_enc_model i_enc (.clk(clk), .step(step), .dir(dir), .refMark(refMark), .dog(dog));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for ready however long the slave takes; the cycle ceiling ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask

  task automatic do_reset(input logic sw);
    testSw <= sw;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic wait_done;
    for (int n = 0; n < 200 && homeDone !== 1'b1; n++) begin
      @(posedge clk);
    end
    chk("homeDone", 32'h1, {31'h0, homeDone});
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd("ctrlReset", 8'h00, 32'h30);
    apb(1'b1, 8'h00, 32'h70);
    rd("ctrlBadCode", 8'h00, 32'h30);
    rd("unmapped", 8'h20, 32'h0);
    chk("unmappedErr", 32'h1, {31'h0, rerr});
    chk("netNormal", 32'h3, {30'h0, netSelfEn, netDownOut});
    netUp <= 1'b0;
    repeat (4) @(posedge clk);
    chk("netFollow", 32'h2, {30'h0, netSelfEn, netDownOut});
    netUp <= 1'b1;
    repeat (4) @(posedge clk);
    $display("registers done");
  endtask

  task automatic t_incr;
    apb(1'b1, 8'h00, 32'h1);
    idxPulse <= 1'b1;
    repeat (3) @(posedge clk);
    idxPulse <= 1'b0;
    repeat (3) @(posedge clk);
    rd("statIndexOnly", 8'h04, 32'h1);
    i_enc.move(8210, 9, 19, 1'b0);
    wait_done();
    chk("homeIncr", 32'h200a, homePos);
    rd("irqRefHome", 8'h10, 32'h3);
    apb(1'b1, 8'h10, 32'h3);
    rd("irqCleared", 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    rd("statRestart", 8'h04, 32'h1);
    i_enc.move(8, -1, 0, 1'b0);
    rd("statNoRef", 8'h04, 32'h1);
    chk("busyNoRef", 32'h1, {31'h0, homeBusy});
    $display("incremental done");
  endtask

  task automatic t_abs;
    apb(1'b1, 8'h00, 32'ha);
    absPos <= 32'h6005;
    absLoad <= 1'b1;
    @(posedge clk);
    absLoad <= 1'b0;
    @(posedge clk);
    apb(1'b1, 8'h00, 32'hb);
    i_enc.move(5, -1, 0, 1'b1);
    wait_done();
    chk("homeAbsNeg", 32'h6000, homePos);
    for (int c = 0; c < 7; c++) begin
      apb(1'b1, 8'h00, {25'h0, c[2:0], 4'h2});
      absPos <= 3 * iv[c] - 32'h5;
      absLoad <= 1'b1;
      @(posedge clk);
      absLoad <= 1'b0;
      @(posedge clk);
      apb(1'b1, 8'h00, {25'h0, c[2:0], 4'h3});
      i_enc.move(5, -1, 0, 1'b0);
      wait_done();
      chk("homeAbs", 3 * iv[c], homePos);
    end
    $display("absolute done");
  endtask

  task automatic t_dset;
    apb(1'b1, 8'h00, 32'h35);
    chk("dsetDone", 32'h1, {31'h0, homeDone});
    chk("dsetPos", 32'h0c00_0000, homePos);
    chk("dsetPosNow", 32'h0c00_0000, posNow);
    $display("data set done");
  endtask

  task automatic t_reject;
    apb(1'b1, 8'h18, 32'h11);
    rd("testIgnored", 8'h18, 32'h0);
    chk("irqMasked", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h14, 32'h4);
    repeat (2) @(posedge clk);
    chk("irqRaised", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h10, 32'h4);
    repeat (2) @(posedge clk);
    chk("irqCleared", 32'h0, {31'h0, irq});
    $display("reject done");
  endtask

  task automatic t_testmode;
    logic [31:0] cmd [3] = '{32'h11, 32'h30, 32'h40};
    logic [31:0] exp [3] = '{32'h14, 32'h0c, 32'h09};
    do_reset(1'b1);
    chk("netTest", 32'h0, {30'h0, netSelfEn, netDownOut});
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h18, cmd[i]);
      repeat (2) @(posedge clk);
      chk("axisCmd", exp[i], {27'h0, axisMoveEn, testMovePos, testMoveNeg, testProgRun});
    end
    apb(1'b1, 8'h18, 32'h42);
    repeat (2) @(posedge clk);
    chk("axisBad", 32'h09, {27'h0, axisMoveEn, testMovePos, testMoveNeg, testProgRun});
    rd("irqReject", 8'h10, 32'h4);
    apb(1'b1, 8'h1c, 32'h1a5);
    repeat (2) @(posedge clk);
    chk("forceOut", 32'h1a5, {23'h0, doForceEn, doForceVal});
    $display("test mode done");
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Longest run is the incremental seek, about 33000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    absPos = 32'h0;
    absLoad = 1'b0;
    idxPulse = 1'b0;
    testSw = 1'b0;
    netUp = 1'b1;
    @(posedge clk);
    do_reset(1'b0);
    t_regs();
    t_incr();
    t_abs();
    t_dset();
    t_reject();
    t_testmode();
    report_and_stop();
  end
endmodule
`default_nettype wire
